// File: pkg/exit_save_pkg.sv
// Function
// - an asynchronous exit saves state into the frame picked by the current frame index
// - the extended-state region is written from byte 0 of the frame, non-compacted
// - the extended-state size is taken from the software-written XSIZE register, rounded up to 8-byte words
// - the general-register region starts 176 bytes below the frame end and holds 23 words, so its last word lands past the frame end
// - with extra-info supported, that region sits just below the general-register region
// - bytes between the extended-state region and the next region up are left untouched
// - sixteen general registers are saved as 8-byte entries at offsets 0 through 120
// - flags go to offset 128 and instruction pointer to 136, 8 bytes each
// - entry records outside stack and frame pointers at 144 and 152, exit restores them
// - a 4-byte exit-information word is written at offset 160
// - notify is delivered only if bit 0 of byte 167 of the current frame is 1
// - the frame index goes up by one on each completed save and down by one on each resume while it is nonzero and no save completes in the same cycle
// - exit info holds vector in 7:0, type in 10:8 and a valid flag in bit 31
// - extra-info component i below MISC_MAX is saved if and only if select bit i is 1 and EXTRA_SUPPORTED is nonzero
package exit_save_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] BASE_LO_OFS = 8'h04;
  localparam logic [7:0] BASE_HI_OFS = 8'h08;
  localparam logic [7:0] FSIZE_OFS   = 8'h0C;
  localparam logic [7:0] INDEX_OFS   = 8'h10;
  localparam logic [7:0] NFRAME_OFS  = 8'h14;
  localparam logic [7:0] XSIZE_OFS   = 8'h18;
  localparam logic [7:0] XSEL_OFS    = 8'h1C;
  localparam logic [7:0] XSUP_OFS    = 8'h20;
  localparam logic [7:0] STATUS_OFS  = 8'h24;
  localparam logic [7:0] MASK_OFS    = 8'h28;
  // reset values
  localparam logic [31:0] FSIZE_RST  = 32'h0000_1000;
  localparam logic [31:0] NFRAME_RST = 32'h0000_0001;
  localparam logic [31:0] XSIZE_RST  = 32'h0000_0200;
  // frame layout
  localparam logic [63:0] GPR_SIZE    = 64'h0000_0000_0000_00B0;
  localparam logic [15:0] GPR_WORDS   = 16'h0017;
  localparam logic [15:0] INFO_WORD   = 16'h0014;
  localparam logic [63:0] XCOMP_BYTES = 64'h0000_0000_0000_0010;
  localparam logic [7:0]  INFO_STRB   = 8'h0F;
  // status bits and bus responses
  localparam int EV_DONE = 0;
  localparam int EV_OVF  = 1;
  localparam int EV_RES  = 2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_XST  = 3'h1,
    S_MISC = 3'h3,
    S_GPR  = 3'h2,
    S_DONE = 3'h6
  } state_t;

  typedef struct packed {
    logic [15:0][63:0] gpr;
    logic [63:0]       flags;
    logic [63:0]       ip;
    logic [63:0]       fs_segment_base;
    logic [63:0]       gs_segment_base;
    logic [7:0]        vector;
    logic [2:0]        exit_type;
    logic              reported;
    logic [63:0]       fault_addr;
    logic [31:0]       err_code;
  } exit_state_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [7:0]  strb;
  } mem_wr_t;
endpackage

// File: rtl/enclave_exit_state_save.sv
`timescale 1ns/1ps
module enclave_exit_state_save #(
  parameter int          MISC_MAX        = 2,
  parameter logic [31:0] EXTRA_SUPPORTED = 32'h0000_0003
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       exit_req,
  input  wire exit_save_pkg::exit_state_t exit_state,
  input  wire logic                       resume_req,
  input  wire logic                       enter_req,
  input  wire logic [63:0]                enter_sp,
  input  wire logic [63:0]                enter_fp,
  input  wire logic [7:0]                 notify_byte,
  output logic [15:0]                     xstate_idx,
  input  wire logic [63:0]                xstate_data,
  output logic                            mem_valid,
  output exit_save_pkg::mem_wr_t          mem_wr,
  input  wire logic                       mem_ready,
  output logic                            busy,
  output logic                            restore_valid,
  output logic [63:0]                     restore_sp,
  output logic [63:0]                     restore_fp,
  output logic                            notify_deliver,
  output logic                            irq
);

  // register file
  logic        ctrl_en_q;
  logic [63:0] ossa_q;
  logic [31:0] fsize_q;
  logic [31:0] index_q;
  logic [31:0] nframe_q;
  logic [31:0] xsize_q;
  logic [31:0] xsel_q;
  logic [2:0]  status_q;
  logic [2:0]  status_d;
  logic [2:0]  mask_q;
  // bus side
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] rd_val;
  // save engine
  exit_save_pkg::state_t      state_q;
  exit_save_pkg::exit_state_t st_q;
  logic [15:0] cnt_q;
  logic [63:0] frame_base_q;
  logic [63:0] gpr_base_q;
  logic [63:0] osp_q;
  logic [63:0] ofp_q;
  logic [63:0] fb_next;
  logic [15:0] xwords;
  logic        can;
  logic        start;
  logic        ovf;
  logic        done_pulse;
  logic [15:0] comp;
  logic        misc_on;
  logic [63:0] misc_data;

  // address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= exit_save_pkg::MASK_OFS);
  endfunction

  // byte-lane merge of a write into a 32-bit register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  // word i of the general-register region
  function automatic logic [63:0] gpr_word(input exit_save_pkg::exit_state_t s,
                                           input logic [63:0] sp, input logic [63:0] fp,
                                           input logic [15:0] i);
    logic [31:0] info;
    info = {s.reported, 20'h0_0000, s.reported ? s.exit_type : 3'h0,
            s.reported ? s.vector : 8'h00};
    case (i)
      16'h0010: gpr_word = s.flags;
      16'h0011: gpr_word = s.ip;
      16'h0012: gpr_word = sp;
      16'h0013: gpr_word = fp;
      16'h0014: gpr_word = {32'h0000_0000, info};
      16'h0015: gpr_word = s.fs_segment_base;
      16'h0016: gpr_word = s.gs_segment_base;
      default:  gpr_word = s.gpr[i[3:0]];
    endcase
  endfunction

  // write channel handshakes and response
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= exit_save_pkg::RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_q) ? exit_save_pkg::RESP_OK : exit_save_pkg::RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_hold_q     <= 1'b0;
        w_hold_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read mux
  always_comb begin
    case (s_axi_araddr)
      exit_save_pkg::CTRL_OFS:    rd_val = {31'h0000_0000, ctrl_en_q};
      exit_save_pkg::BASE_LO_OFS: rd_val = ossa_q[31:0];
      exit_save_pkg::BASE_HI_OFS: rd_val = ossa_q[63:32];
      exit_save_pkg::FSIZE_OFS:   rd_val = fsize_q;
      exit_save_pkg::INDEX_OFS:   rd_val = index_q;
      exit_save_pkg::NFRAME_OFS:  rd_val = nframe_q;
      exit_save_pkg::XSIZE_OFS:   rd_val = xsize_q;
      exit_save_pkg::XSEL_OFS:    rd_val = xsel_q;
      exit_save_pkg::XSUP_OFS:    rd_val = EXTRA_SUPPORTED;
      exit_save_pkg::STATUS_OFS:  rd_val = {29'h0000_0000, status_q};
      exit_save_pkg::MASK_OFS:    rd_val = {29'h0000_0000, mask_q};
      default:                    rd_val = 32'h0000_0000;
    endcase
  end

  // read channel: one-cycle answer after the address is taken
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= exit_save_pkg::RESP_OK;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= mapped(s_axi_araddr) ? exit_save_pkg::RESP_OK : exit_save_pkg::RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // software-written configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_q <= 1'b0;
      ossa_q    <= 64'h0000_0000_0000_0000;
      fsize_q   <= exit_save_pkg::FSIZE_RST;
      nframe_q  <= exit_save_pkg::NFRAME_RST;
      xsize_q   <= exit_save_pkg::XSIZE_RST;
      xsel_q    <= 32'h0000_0000;
      mask_q    <= 3'h0;
    end else if (wr_fire) begin
      case (aw_addr_q)
        exit_save_pkg::CTRL_OFS:    ctrl_en_q <= w_strb_q[0] ? w_data_q[0] : ctrl_en_q;
        exit_save_pkg::BASE_LO_OFS: ossa_q[31:0] <= merge(ossa_q[31:0], w_data_q, w_strb_q);
        exit_save_pkg::BASE_HI_OFS: ossa_q[63:32] <= merge(ossa_q[63:32], w_data_q, w_strb_q);
        exit_save_pkg::FSIZE_OFS:   fsize_q <= merge(fsize_q, w_data_q, w_strb_q);
        exit_save_pkg::NFRAME_OFS:  nframe_q <= merge(nframe_q, w_data_q, w_strb_q);
        exit_save_pkg::XSIZE_OFS:   xsize_q <= merge(xsize_q, w_data_q, w_strb_q);
        exit_save_pkg::XSEL_OFS:    xsel_q <= merge(xsel_q, w_data_q, w_strb_q);
        exit_save_pkg::MASK_OFS:    mask_q <= w_strb_q[0] ? w_data_q[2:0] : mask_q;
        default:                    ctrl_en_q <= ctrl_en_q;
      endcase
    end
  end

  // exit acceptance and frame address
  assign start   = exit_req && ctrl_en_q && (state_q == exit_save_pkg::S_IDLE)
                   && (index_q < nframe_q);
  assign ovf     = exit_req && ctrl_en_q && (state_q == exit_save_pkg::S_IDLE)
                   && (index_q >= nframe_q);
  assign fb_next = ossa_q + 64'(index_q) * 64'(fsize_q);
  assign xwords  = 16'((xsize_q + 32'h0000_0007) >> 3);
  assign can     = !mem_valid || mem_ready;
  assign done_pulse = (state_q == exit_save_pkg::S_DONE) && can;
  assign comp    = cnt_q >> 1;
  assign misc_on = (EXTRA_SUPPORTED != 32'h0000_0000) && (comp < 16'(MISC_MAX))
                   && xsel_q[comp[4:0]];
  assign misc_data = (comp == 16'h0000)
                     ? (cnt_q[0] ? st_q.fault_addr : {32'h0000_0000, st_q.err_code})
                     : 64'h0000_0000_0000_0000;
  assign xstate_idx = cnt_q;

  // outside pointers recorded at entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osp_q <= 64'h0000_0000_0000_0000;
      ofp_q <= 64'h0000_0000_0000_0000;
    end else if (enter_req) begin
      osp_q <= enter_sp;
      ofp_q <= enter_fp;
    end
  end

  // save sequencer and memory write port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= exit_save_pkg::S_IDLE;
      cnt_q        <= 16'h0000;
      st_q         <= '0;
      frame_base_q <= 64'h0000_0000_0000_0000;
      gpr_base_q   <= 64'h0000_0000_0000_0000;
      mem_valid    <= 1'b0;
      mem_wr       <= '0;
    end else begin
      if (mem_valid && mem_ready) begin
        mem_valid <= 1'b0;
      end
      case (state_q)
        exit_save_pkg::S_IDLE: begin
          if (start) begin
            st_q         <= exit_state;
            frame_base_q <= fb_next;
            gpr_base_q   <= fb_next + 64'(fsize_q) - exit_save_pkg::GPR_SIZE;
            cnt_q        <= 16'h0000;
            state_q      <= (xwords == 16'h0000) ? exit_save_pkg::S_MISC : exit_save_pkg::S_XST;
          end
        end
        exit_save_pkg::S_XST: begin
          if (can) begin
            mem_valid   <= 1'b1;
            mem_wr.addr <= frame_base_q + {45'h0, cnt_q, 3'h0};
            mem_wr.data <= xstate_data;
            mem_wr.strb <= 8'hFF;
            cnt_q       <= cnt_q + 16'h0001;
            if (cnt_q == xwords - 16'h0001) begin
              cnt_q   <= 16'h0000;
              state_q <= exit_save_pkg::S_MISC;
            end
          end
        end
        exit_save_pkg::S_MISC: begin
          if (can) begin
            if (misc_on) begin
              mem_valid   <= 1'b1;
              mem_wr.addr <= gpr_base_q - exit_save_pkg::XCOMP_BYTES * 64'(comp + 16'h0001)
                             + {60'h0, cnt_q[0], 3'h0};
              mem_wr.data <= misc_data;
              mem_wr.strb <= 8'hFF;
            end
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q >= 16'(2 * MISC_MAX - 1)) begin
              cnt_q   <= 16'h0000;
              state_q <= exit_save_pkg::S_GPR;
            end
          end
        end
        exit_save_pkg::S_GPR: begin
          if (can) begin
            mem_valid   <= 1'b1;
            mem_wr.addr <= gpr_base_q + {45'h0, cnt_q, 3'h0};
            mem_wr.data <= gpr_word(st_q, osp_q, ofp_q, cnt_q);
            // only the low four bytes at 160; byte 167 stays software-owned
            mem_wr.strb <= (cnt_q == exit_save_pkg::INFO_WORD) ? exit_save_pkg::INFO_STRB
                                                              : 8'hFF;
            cnt_q       <= cnt_q + 16'h0001;
            if (cnt_q == exit_save_pkg::GPR_WORDS - 16'h0001) begin
              cnt_q   <= 16'h0000;
              state_q <= exit_save_pkg::S_DONE;
            end
          end
        end
        exit_save_pkg::S_DONE: begin
          if (can) begin
            state_q <= exit_save_pkg::S_IDLE;
          end
        end
        default: state_q <= exit_save_pkg::S_IDLE;
      endcase
    end
  end

  // current frame index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_q <= 32'h0000_0000;
    end else if (done_pulse) begin
      index_q <= index_q + 32'h0000_0001;
    end else if (resume_req && index_q != 32'h0000_0000) begin
      index_q <= index_q - 32'h0000_0001;
    end else if (wr_fire && aw_addr_q == exit_save_pkg::INDEX_OFS) begin
      index_q <= merge(index_q, w_data_q, w_strb_q);
    end
  end

  // exit completion outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy           <= 1'b0;
      restore_valid  <= 1'b0;
      restore_sp     <= 64'h0000_0000_0000_0000;
      restore_fp     <= 64'h0000_0000_0000_0000;
      notify_deliver <= 1'b0;
    end else begin
      busy           <= start || (busy && !done_pulse);
      restore_valid  <= done_pulse;
      notify_deliver <= done_pulse && notify_byte[0];
      if (done_pulse) begin
        restore_sp <= osp_q;
        restore_fp <= ofp_q;
      end
    end
  end

  // sticky status, read clears, a new event wins over the clear
  always_comb begin
    status_d = status_q;
    if (rd_fire && s_axi_araddr == exit_save_pkg::STATUS_OFS) begin
      status_d = 3'h0;
    end
    status_d[exit_save_pkg::EV_DONE] = status_d[exit_save_pkg::EV_DONE] | done_pulse;
    status_d[exit_save_pkg::EV_OVF]  = status_d[exit_save_pkg::EV_OVF] | ovf;
    status_d[exit_save_pkg::EV_RES]  = status_d[exit_save_pkg::EV_RES] | resume_req;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 3'h0;
      irq      <= 1'b0;
    end else begin
      status_q <= status_d;
      irq      <= |(status_d & mask_q);
    end
  end

endmodule // enclave_exit_state_save

// File: tb/exit_save_asserts.sv
`timescale 1ns/1ps
module exit_save_asserts (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   mem_valid,
  input wire logic                   mem_ready,
  input wire exit_save_pkg::mem_wr_t mem_wr,
  input wire logic                   restore_valid,
  input wire logic [63:0]            restore_sp,
  input wire logic [7:0]             notify_byte,
  input wire logic                   notify_deliver
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus handshakes answer and hold
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_mem_hold;
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_wr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("frame write dropped");
  // frame writes and exit completion
  property p_mem_align;
    mem_valid |-> mem_wr.addr[2:0] == 3'h0;
  endproperty
  a_mem_align: assert property (p_mem_align) else $error("unaligned word");
  property p_info_strb;
    mem_valid |-> mem_wr.strb == 8'hFF || mem_wr.strb == exit_save_pkg::INFO_STRB;
  endproperty
  a_info_strb: assert property (p_info_strb) else $error("bad strobe");
  property p_restore_pulse;
    restore_valid |=> !restore_valid;
  endproperty
  a_restore_pulse: assert property (p_restore_pulse) else $error("long pulse");
  property p_restore_ptr;
    $changed(restore_sp) |-> restore_valid;
  endproperty
  a_restore_ptr: assert property (p_restore_ptr) else $error("stray pointer");
  property p_notify;
    restore_valid || notify_deliver |-> restore_valid && notify_deliver == $past(notify_byte[0]);
  endproperty
  a_notify: assert property (p_notify) else $error("notify mismatch");
  c_notify: cover property (restore_valid && notify_deliver);
  c_stall: cover property (mem_valid && !mem_ready);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == exit_save_pkg::RESP_ERR);
endmodule // exit_save_asserts

bind enclave_exit_state_save exit_save_asserts chk_u (.*);

// File: tb/frame_mem_model.sv
`timescale 1ns/1ps
module frame_mem_model (
  input wire logic                   aclk,
  input wire logic                   slow,
  input wire logic                   mem_valid,
  input wire exit_save_pkg::mem_wr_t mem_wr,
  output logic                       mem_ready,
  input wire logic [15:0]            xstate_idx,
  output logic [63:0]                xstate_data
);
  logic [63:0] mem [logic [63:0]];
  logic [1:0]  tick_q = 2'h0;
  logic [63:0] word;
  // extended-state source, answered in the same cycle
  assign xstate_data = {xstate_idx, 16'hC3C3, ~xstate_idx, 16'h3C3C};
  // ready each cycle, or one cycle in three while slow
  initial mem_ready = 1'b0;
  always @(posedge aclk) begin
    tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
    mem_ready <= !slow || tick_q == 2'h1;
  end
  // byte-lane merge of each accepted word
  always @(posedge aclk) begin
    if (mem_valid && mem_ready) begin
      word = mem.exists(mem_wr.addr) ? mem[mem_wr.addr] : 64'h0;
      for (int b = 0; b < 8; b++)
        if (mem_wr.strb[b]) word[8*b +: 8] = mem_wr.data[8*b +: 8];
      mem[mem_wr.addr] = word;
    end
  end
endmodule // frame_mem_model

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, notify_byte = 8'h00;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        exit_req = 1'b0, resume_req = 1'b0, enter_req = 1'b0;
  logic [63:0] enter_sp = 64'h0, enter_fp = 64'h0;
  exit_save_pkg::exit_state_t exit_state = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [15:0] xstate_idx;
  logic [63:0] xstate_data, restore_sp, restore_fp, fb, gb;
  logic        mem_valid, mem_ready, busy, restore_valid, notify_deliver, irq, rv, nd;
  exit_save_pkg::mem_wr_t mem_wr;
  int          miscompares = 0, compares = 0;

  always #2.5 aclk = ~aclk;

  enclave_exit_state_save #(.MISC_MAX(2)) dut_u (.*);
  frame_mem_model mem_u (
    .aclk, .slow, .mem_valid, .mem_wr, .mem_ready, .xstate_idx, .xstate_data
  );

  task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic stuck();
    miscompares++;
    $display("wrong value at %0t: wait ran out", $time);
    close_out();
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one write: address and data offered together, held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) stuck();
  endtask

  // one read, address held until taken
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) stuck();
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, resp);
    check(resp, exit_save_pkg::RESP_OK);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, resp);
    check({resp, rd}, {exit_save_pkg::RESP_OK, exp});
  endtask

  // exit pulse, then optionally wait for the completion pulse
  task automatic do_exit(input logic [7:0] nb, input bit w);
    @(posedge aclk);
    notify_byte <= nb;
    exit_req <= 1'b1;
    @(posedge aclk);
    exit_req <= 1'b0;
    rv = 1'b0;
    for (int n = 0; n < 600 && w && !rv; n++) begin
      @(posedge aclk);
      rv = restore_valid;
      nd = notify_deliver;
    end
    if (w && !rv) stuck();
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(exit_save_pkg::CTRL_OFS, 32'h0);
    rd_chk(exit_save_pkg::FSIZE_OFS, exit_save_pkg::FSIZE_RST);
    rd_chk(exit_save_pkg::NFRAME_OFS, exit_save_pkg::NFRAME_RST);
    rd_chk(exit_save_pkg::XSIZE_OFS, exit_save_pkg::XSIZE_RST);
    rd_chk(exit_save_pkg::XSUP_OFS, 32'h0000_0003);
    axi_rd(8'h2C, rd, resp);
    check(resp, exit_save_pkg::RESP_ERR);
    axi_wr(8'h02, 32'h1, resp);
    check(resp, exit_save_pkg::RESP_ERR);
    // page-aligned frames of one page each, two of them
    wr_ok(exit_save_pkg::BASE_LO_OFS, 32'h0001_0000);
    wr_ok(exit_save_pkg::BASE_HI_OFS, 32'h0);
    wr_ok(exit_save_pkg::NFRAME_OFS, 32'h2);
    wr_ok(exit_save_pkg::XSIZE_OFS, 32'h20);
    wr_ok(exit_save_pkg::XSEL_OFS, 32'h1);
    wr_ok(exit_save_pkg::MASK_OFS, 32'h1);
    wr_ok(exit_save_pkg::CTRL_OFS, 32'h1);
    enter_sp <= 64'h0000_7FFF_0000_1100;
    enter_fp <= 64'h0000_7FFF_0000_1180;
    enter_req <= 1'b1;
    @(posedge aclk);
    enter_req <= 1'b0;
    for (int i = 0; i < 16; i++) exit_state.gpr[i] <= 64'hA000 + i;
    exit_state.flags <= 64'h246;
    exit_state.ip <= 64'h4000_1234;
    exit_state.fs_segment_base <= 64'hF500_0000;
    exit_state.gs_segment_base <= 64'h6500_0000;
    exit_state.vector <= 8'h0E;
    exit_state.exit_type <= 3'h3;
    exit_state.reported <= 1'b1;
    exit_state.fault_addr <= 64'hDEAD_0000;
    exit_state.err_code <= 32'h6;
    slow <= 1'b1;
    do_exit(8'h01, 1'b1);
    check({rv, nd}, 2'b11);
    check(busy, 1'b0);
    check(restore_sp, enter_sp);
    check(restore_fp, enter_fp);
    fb = 64'h0001_0000;
    gb = fb + 64'h1000 - 64'd176;
    for (int k = 0; k < 4; k++)
      check(mem_u.mem[fb + 64'(8*k)], {k[15:0], 16'hC3C3, ~k[15:0], 16'h3C3C});
    check(mem_u.mem.exists(fb + 64'h20), 0);
    for (int i = 0; i < 16; i++) check(mem_u.mem[gb + 64'(8*i)], 64'hA000 + i);
    check(mem_u.mem[gb + 64'd128], 64'h246);
    check(mem_u.mem[gb + 64'd136], 64'h4000_1234);
    check(mem_u.mem[gb + 64'd144], enter_sp);
    check(mem_u.mem[gb + 64'd152], enter_fp);
    check(mem_u.mem[gb + 64'd160], 64'h8000_030E);
    check(mem_u.mem[gb + 64'd168], 64'hF500_0000);
    check(mem_u.mem[gb + 64'd176], 64'h6500_0000);
    check(mem_u.mem[gb - 64'd16], 64'h6);
    check(mem_u.mem[gb - 64'd8], 64'hDEAD_0000);
    check(mem_u.mem.exists(gb - 64'd32), 0);
    rd_chk(exit_save_pkg::INDEX_OFS, 32'h1);
    check(irq, 1'b1);
    rd_chk(exit_save_pkg::STATUS_OFS, 32'h1);
    @(posedge aclk);
    check(irq, 1'b0);
    // second frame, unreported cause, notify off, no extra info
    wr_ok(exit_save_pkg::XSEL_OFS, 32'h0);
    slow <= 1'b0;
    exit_state.reported <= 1'b0;
    exit_state.gpr[0] <= 64'hB000;
    do_exit(8'h00, 1'b1);
    check({rv, nd}, 2'b10);
    gb = 64'h0001_1000 + 64'h1000 - 64'd176;
    check(mem_u.mem[gb], 64'hB000);
    check(mem_u.mem[gb + 64'd160], 64'h0);
    check(mem_u.mem.exists(gb - 64'd16), 0);
    rd_chk(exit_save_pkg::INDEX_OFS, 32'h2);
    rd_chk(exit_save_pkg::STATUS_OFS, 32'h1);
    // no frame left: overflow flagged, masked from the interrupt
    do_exit(8'h01, 1'b0);
    rd_chk(exit_save_pkg::INDEX_OFS, 32'h2);
    check(irq, 1'b0);
    rd_chk(exit_save_pkg::STATUS_OFS, 32'h2);
    // three resumes, the last one at index zero
    repeat (3) begin
      @(posedge aclk);
      resume_req <= 1'b1;
      @(posedge aclk);
      resume_req <= 1'b0;
    end
    rd_chk(exit_save_pkg::INDEX_OFS, 32'h0);
    rd_chk(exit_save_pkg::STATUS_OFS, 32'h4);
    close_out();
  end
endmodule // tb
